// *** common/srw_pkg.sv ***
package srw_pkg;
    // Instruction codes
    localparam logic [7:0]  OP_CALL_SUB    = 8'h17;
    localparam logic [7:0]  OP_RETURN_SUB  = 8'h18;
    localparam logic [7:0]  OP_COND_JUMP   = 8'h15;
    localparam logic [7:0]  OP_CLEAR_ERR   = 8'h24;
    localparam logic [7:0]  OP_WAIT        = 8'h1B;
    // Wait types, timeout jump condition and accumulator count marker
    localparam logic [7:0]  WAIT_TICKS     = 8'h00;
    localparam logic [7:0]  WAIT_POS       = 8'h01;
    localparam logic [7:0]  WAIT_HOME      = 8'h02;
    localparam logic [7:0]  WAIT_END       = 8'h03;
    localparam logic [7:0]  WAIT_HOMING    = 8'h04;
    localparam logic [7:0]  JC_TIMEOUT     = 8'h08;
    localparam logic [31:0] TICKS_FROM_ACC = 32'hFFFFFFFF;
    // Call stack
    localparam int          STACK_DEPTH    = 8;
    localparam logic [3:0]  STACK_FULL     = 4'h8;
    localparam logic [3:0]  STACK_EMPTY    = 4'h0;
    localparam int          PC_W           = 16;
    localparam int          MOTORS         = 1;
    // Timebase
    localparam int          CLK_HZ         = 125_000_000;
    localparam int          TICK_MS        = 10;
    localparam longint      TICK_CYCLES_L  = longint'(CLK_HZ) * TICK_MS / 1000;
    localparam int          TICK_CYCLES    = int'(TICK_CYCLES_L);
    localparam logic [20:0] TICK_RST       = 21'h000000;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  typ;
        logic [7:0]  motor;
        logic [31:0] value;
    } srw_instr_s;

    typedef struct packed {
        logic pos_reached;
        logic home_sw;
        logic end_sw_left;
        logic end_sw_right;
        logic homing_done;
    } srw_motion_s;
endpackage

// *** rtl/srw_sequencer.sv ***
module srw_sequencer
    import srw_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_exec,
    input  wire srw_instr_s        i_instr, // Decoded frame fields, value MSB first
    input  wire logic [PC_W-1:0]   i_pc,
    input  wire logic [31:0]       i_acc,
    input  wire srw_motion_s       i_motion,
    output logic                   o_done,
    output logic                   o_busy,
    output logic [PC_W-1:0]        o_next_pc,
    output logic                   o_timeout_error_flag,
    output logic [3:0]             o_stack_level
);
    typedef enum logic [1:0] {
        SRW_IDLE = 2'b01,
        SRW_WAIT = 2'b10
    } srw_state_e;

    srw_state_e            state;
    logic [20:0]           tick_div;
    logic                  tick;
    logic [31:0]           tick_cnt;
    logic [31:0]           limit;
    logic [7:0]            wtype;
    logic [PC_W-1:0]       stack [STACK_DEPTH];
    logic [3:0]            sp;
    logic [PC_W-1:0]       wait_pc;
    logic [2:0]            s1;
    logic [2:0]            s2;
    logic [2:0]            s3;
    logic                  pos_ok;
    logic                  home_ok;
    logic                  end_ok;
    logic                  homing_ok;
    logic                  cond;
    logic                  expire;
    logic                  start_wait;
    logic [31:0]           next_limit;

    // Switch inputs come from pins: three stages, change accepted when 2 and 3 agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            s3 <= 3'h0;
        end else begin
            s1 <= {i_motion.home_sw, i_motion.end_sw_left | i_motion.end_sw_right,
                   i_motion.homing_done};
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            home_ok   <= 1'b0;
            end_ok    <= 1'b0;
            homing_ok <= 1'b0;
        end else begin
            if (s2[2] == s3[2]) home_ok <= s3[2];
            if (s2[1] == s3[1]) end_ok <= s3[1];
            if (s2[0] == s3[0]) homing_ok <= s3[0];
        end
    end
    assign pos_ok = i_motion.pos_reached;

    // 10 ms timebase
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_div <= TICK_RST;
            tick     <= 1'b0;
        end else if (tick_div == 21'(TICK_CYCLES - 1)) begin
            tick_div <= TICK_RST;
            tick     <= 1'b1;
        end else begin
            tick_div <= tick_div + 21'h000001;
            tick     <= 1'b0;
        end
    end

    assign start_wait = i_exec && state == SRW_IDLE && i_instr.opcode == OP_WAIT;
    assign next_limit = (i_instr.value == TICKS_FROM_ACC) ? i_acc : i_instr.value;

    always_comb begin
        case (wtype)
            WAIT_TICKS:  cond = 1'b0;
            WAIT_POS:    cond = pos_ok;
            WAIT_HOME:   cond = home_ok;
            WAIT_END:    cond = end_ok;
            WAIT_HOMING: cond = homing_ok;
            default:     cond = 1'b1;
        endcase
    end
    // Ticks type ends on count; others time out only when limit non-zero
    assign expire = (limit != 32'h0 || wtype == WAIT_TICKS) && tick_cnt == limit;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state    <= SRW_IDLE;
            tick_cnt <= 32'h0;
            limit    <= 32'h0;
            wtype    <= 8'h00;
            wait_pc  <= '0;
        end else begin
            case (state)
                SRW_IDLE: begin
                    if (start_wait) begin
                        state    <= SRW_WAIT;
                        tick_cnt <= 32'h0;
                        limit    <= next_limit;
                        wtype    <= i_instr.typ;
                        wait_pc  <= i_pc;
                    end
                end
                SRW_WAIT: begin
                    if (cond || expire) begin
                        state <= SRW_IDLE;
                    end else if (tick) begin
                        tick_cnt <= tick_cnt + 32'h1;
                    end
                end
                default: state <= SRW_IDLE;
            endcase
        end
    end

    // Timeout error flag: set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_timeout_error_flag <= 1'b0;
        end else if (state == SRW_WAIT && !cond && expire && wtype != WAIT_TICKS) begin
            o_timeout_error_flag <= 1'b1;
        end else if (i_exec && state == SRW_IDLE && i_instr.opcode == OP_CLEAR_ERR) begin
            o_timeout_error_flag <= 1'b0;
        end
    end

    // Call stack
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp <= STACK_EMPTY;
        end else if (i_exec && state == SRW_IDLE) begin
            if (i_instr.opcode == OP_CALL_SUB && sp != STACK_FULL) begin
                sp <= sp + 4'h1;
            end else if (i_instr.opcode == OP_RETURN_SUB && sp != STACK_EMPTY) begin
                sp <= sp - 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_exec && state == SRW_IDLE && i_instr.opcode == OP_CALL_SUB && sp != STACK_FULL)
            stack[sp[2:0]] <= i_pc;
    end

    // Next program counter and completion
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done    <= 1'b0;
            o_next_pc <= '0;
        end else begin
            o_done <= 1'b0;
            if (state == SRW_WAIT) begin
                o_next_pc <= wait_pc;
                if (cond || expire) begin
                    o_done    <= 1'b1;
                    o_next_pc <= wait_pc + 16'h1;
                end
            end else if (i_exec && !start_wait) begin
                o_done <= 1'b1;
                case (i_instr.opcode)
                    OP_RETURN_SUB: begin
                        if (sp != STACK_EMPTY)
                            o_next_pc <= stack[3'(sp - 4'h1)] + 16'h1;
                        else
                            o_next_pc <= i_pc + 16'h1;
                    end
                    OP_CALL_SUB: begin
                        o_next_pc <= (sp != STACK_FULL) ? i_instr.value[PC_W-1:0]
                                                        : i_pc + 16'h1;
                    end
                    OP_COND_JUMP: begin
                        o_next_pc <= (i_instr.typ == JC_TIMEOUT && o_timeout_error_flag)
                                     ? i_instr.value[PC_W-1:0] : i_pc + 16'h1;
                    end
                    default: o_next_pc <= i_pc + 16'h1;
                endcase
            end else if (start_wait) begin
                o_next_pc <= i_pc;
            end
        end
    end

    assign o_busy        = (state == SRW_WAIT);
    assign o_stack_level = sp;

    AST_RET_EMPTY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_exec && state == SRW_IDLE && i_instr.opcode == OP_RETURN_SUB && sp == STACK_EMPTY)
        |=> o_done && o_next_pc == $past(i_pc) + 16'h1 && sp == STACK_EMPTY)
        else $error("return on empty stack did not advance");
    AST_CALL_FULL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_exec && state == SRW_IDLE && i_instr.opcode == OP_CALL_SUB && sp == STACK_FULL)
        |=> sp == STACK_FULL)
        else $error("call on full stack changed stack");
    AST_HOLD_PC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == SRW_WAIT && !(cond || expire)) |=> !o_done && o_next_pc == wait_pc)
        else $error("program counter moved during wait");
    AST_ETO_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == SRW_WAIT && !cond && expire && wtype != WAIT_TICKS)
        |=> o_timeout_error_flag && state == SRW_IDLE)
        else $error("timeout did not set error flag");
    AST_NO_TIMEOUT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == SRW_WAIT && wtype != WAIT_TICKS && limit == 32'h0 && !cond)
        |=> state == SRW_WAIT)
        else $error("zero timeout ended wait");
    AST_START_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        start_wait |=> tick_cnt == 32'h0 && state == SRW_WAIT)
        else $error("wait counter not cleared");
    AST_ACC_TICKS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (start_wait && i_instr.value == TICKS_FROM_ACC) |=> limit == $past(i_acc))
        else $error("accumulator not used as count");
    AST_TICK_PERIOD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick |=> !tick [*8])
        else $error("ticks too close");
    AST_POS_DONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == SRW_WAIT && wtype == WAIT_POS && pos_ok) |=> o_done && state == SRW_IDLE)
        else $error("position wait did not end");

    sequence s_ret_pop;
        i_exec && state == SRW_IDLE && i_instr.opcode == OP_RETURN_SUB && sp != STACK_EMPTY;
    endsequence
    sequence s_wait_start;
        start_wait;
    endsequence
    AST_RET_POP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_ret_pop |=> o_done && sp == $past(sp) - 4'h1)
        else $error("return did not pop stack");
    AST_WAIT_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_wait_start |=> o_busy && !o_done && o_next_pc == $past(i_pc))
        else $error("wait did not hold program counter");
endmodule

// *** tb/srw_motion_model.sv ***
module srw_motion_model
    import srw_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_arm,
    input  wire logic [2:0] i_sel,
    input  wire logic [7:0] i_delay,
    output srw_motion_s     o_motion
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt;

    // Raises the selected status line once the programmed delay has run out
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt      <= 8'h00;
            o_motion <= '0;
        end else if (!i_arm) begin
            cnt      <= 8'h00;
            o_motion <= '0;
        end else if (cnt != i_delay) begin
            cnt <= cnt + 8'h01;
        end else begin
            o_motion.pos_reached  <= (i_sel == 3'h1);
            o_motion.home_sw      <= (i_sel == 3'h2);
            o_motion.end_sw_left  <= (i_sel == 3'h3);
            o_motion.end_sw_right <= (i_sel == 3'h4);
            o_motion.homing_done  <= (i_sel == 3'h5);
        end
    end
endmodule

// *** tb/testbench.sv ***
`define CHECK(name, exp, got) \
    begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end

module testbench;
    import srw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clk;
    logic            rst_n;
    logic            exec;
    srw_instr_s      instr;
    logic [PC_W-1:0] pc;
    logic [31:0]     acc;
    srw_motion_s     motion;
    logic            done;
    logic            busy;
    logic [PC_W-1:0] next_pc;
    logic            flag;
    logic [3:0]      level;
    logic            arm;
    logic [2:0]      sel;
    logic [7:0]      delay;
    int              miscompares = 0;
    int              n_tests = 0;

    srw_sequencer srw_sequencer_inst (.i_clk(clk), .i_rst_n(rst_n), .i_exec(exec),
        .i_instr(instr), .i_pc(pc), .i_acc(acc), .i_motion(motion), .o_done(done),
        .o_busy(busy), .o_next_pc(next_pc), .o_timeout_error_flag(flag),
        .o_stack_level(level));

    srw_motion_model srw_motion_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_arm(arm),
        .i_sel(sel), .i_delay(delay), .o_motion(motion));

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic issue(input logic [7:0] op, input logic [7:0] typ,
                         input logic [31:0] val, input logic [PC_W-1:0] at);
        @(posedge clk);
        #1;
        instr = '{opcode: op, typ: typ, motor: 8'h03, value: val};
        pc = at;
        exec = 1'b1; // Stored-program sequencer only, never a direct host command
        @(posedge clk);
        #1;
        exec = 1'b0;
    endtask

    task automatic wait_done(input int bound);
        for (int k = 0; k < bound && done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'b1) begin
            $display("MISMATCH done expected 1 seen %b", done);
            miscompares++;
            finish_test();
        end
    endtask

    task automatic step(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val,
                        input logic [PC_W-1:0] at, input logic [PC_W-1:0] exp_pc,
                        input logic [3:0] exp_lvl);
        issue(op, typ, val, at);
        wait_done(10);
        `CHECK("next_pc", exp_pc, next_pc)
        `CHECK("stack_level", exp_lvl, level)
    endtask

    task automatic t_stack();
        for (int i = 0; i < 9; i++) begin
            step(OP_CALL_SUB, 8'h00, 32'h0100 + i, 16'h0010 + i[15:0],
                 (i < 8) ? 16'h0100 + i[15:0] : 16'h0019, (i < 8) ? 4'(i + 1) : STACK_FULL);
        end
        for (int i = 7; i >= 0; i--) begin
            step(OP_RETURN_SUB, 8'h00, 32'h0, 16'h0200, 16'h0011 + i[15:0], 4'(i));
        end
        step(OP_RETURN_SUB, 8'h00, 32'h0, 16'h0040, 16'h0041, STACK_EMPTY);
    endtask

    task automatic t_wait_event(input logic [7:0] typ, input logic [2:0] which,
                                input logic [31:0] tmo);
        issue(OP_WAIT, typ, tmo, 16'h0050);
        `CHECK("busy", 1'b1, busy)
        // A call while waiting must be ignored
        issue(OP_CALL_SUB, 8'h00, 32'h0300, 16'h0050);
        `CHECK("busy_level", 4'h0, level)
        `CHECK("held_pc", 16'h0050, next_pc)
        sel = which;
        delay = 8'h1E;
        arm = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        `CHECK("still_busy", 1'b1, busy)
        wait_done(60);
        `CHECK("wait_pc", 16'h0051, next_pc)
        `CHECK("flag", 1'b0, flag)
        arm = 1'b0;
        // Let the switch synchronisers return to idle before the next wait
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic t_ticks();
        step(OP_WAIT, WAIT_TICKS, 32'h0, 16'h0060, 16'h0061, STACK_EMPTY);
        acc = 32'h0;
        step(OP_WAIT, WAIT_TICKS, TICKS_FROM_ACC, 16'h0070, 16'h0071, STACK_EMPTY);
        step(OP_WAIT, 8'h05, 32'h0, 16'h00C0, 16'h00C1, STACK_EMPTY);
        step(OP_COND_JUMP, JC_TIMEOUT, 32'h0500, 16'h00A0, 16'h00A1, STACK_EMPTY);
        step(OP_CLEAR_ERR, 8'h00, 32'h0, 16'h00B0, 16'h00B1, STACK_EMPTY);
        `CHECK("cleared_flag", 1'b0, flag)
    endtask

    task automatic t_mid_reset();
        step(OP_CALL_SUB, 8'h00, 32'h0400, 16'h0080, 16'h0400, 4'h1);
        rst_n = 1'b0;
        #2;
        `CHECK("rst_level", 4'h0, level)
        `CHECK("rst_pc", 16'h0000, next_pc)
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        step(OP_RETURN_SUB, 8'h00, 32'h0, 16'h0090, 16'h0091, STACK_EMPTY);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        exec = 1'b0;
        instr = '0;
        pc = '0;
        acc = 32'h0;
        arm = 1'b0;
        sel = 3'h0;
        delay = 8'h00;
        repeat (4) @(posedge clk);
        #1;
        `CHECK("reset_done", 1'b0, done)
        `CHECK("reset_flag", 1'b0, flag)
        rst_n = 1'b1;
        t_stack();
        t_wait_event(WAIT_POS, 3'h1, 32'h0);
        t_wait_event(WAIT_HOME, 3'h2, 32'h5);
        t_wait_event(WAIT_END, 3'h3, 32'h0);
        t_wait_event(WAIT_END, 3'h4, 32'h5);
        t_wait_event(WAIT_HOMING, 3'h5, 32'h0);
        t_ticks();
        t_mid_reset();
        finish_test();
    end
endmodule
